// ==== rtl/aro_serial_out.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "aro_defs.svh"
module aro_serial_out #(
  parameter int unsigned NOTCH_WIN_CYC = `ARO_NOTCH_WIN_CYC
) (
  input  wire logic              clk,             // 250 MHz system clock
  input  wire logic              nrst,            // Synchronous reset, active low
  input  wire logic              cs_n_pin,        // Chip select pin, active low
  input  wire logic              sck_in,          // Serial clock pin level
  output logic                   sck_out,         // Serial clock driven in internal mode
  output logic                   sck_oe,          // High while driving serial clock
  output logic                   sdo_out,         // Serial data out
  output logic                   sdo_oe,          // High while driving serial data
  input  wire logic              notch_clock_pin, // External conversion clock pin
  input  wire logic              int_osc_tick,    // Internal oscillator tick, one cycle
  output logic                   osc_en,          // Internal oscillator enable
  output logic                   ext_conv_clk,    // External conversion clock in use
  output logic                   ext_sck_mode,    // External serial clock mode
  output logic                   conv_start,      // Start conversion, one-cycle pulse
  output logic                   conv_busy,       // Conversion running
  output logic                   out_active,      // Data output state
  output logic                   xfer_abort,      // Transfer cut short, one-cycle pulse
  output logic                   conv_tick,       // Conversion clock tick, one cycle
  input  wire logic              res_valid,       // Filter result offered
  output logic                   res_ready,       // Result buffer has space
  input  wire aro_pkg::aro_code_t res_code,       // Two's complement result with sub-LSBs
  input  wire logic              res_over,        // Input above positive full scale
  input  wire logic              res_under        // Input below negative full scale
);
  import aro_pkg::*;

  localparam int unsigned NW = $clog2(NOTCH_WIN_CYC + 1);

  // ----------------------------------------------------------------
  // Pin synchronisers {notch, sck, cs_n}
  // ----------------------------------------------------------------
  logic [2:0] pin_m_q;
  logic [2:0] pin_s_q;
  logic [2:0] pin_d_q;
  logic       cs_n_s;
  logic       cs_fall;
  logic       cs_rise;
  logic       sck_s;
  logic       x_rise;
  logic       x_fall;
  logic       notch_rise;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pin_m_q <= `ARO_PIN_RST;
      pin_s_q <= `ARO_PIN_RST;
      pin_d_q <= `ARO_PIN_RST;
    end else begin
      pin_m_q <= {notch_clock_pin, sck_in, cs_n_pin};
      pin_s_q <= pin_m_q;
      pin_d_q <= pin_s_q;
    end
  end

  assign cs_n_s     = pin_s_q[0];
  assign cs_fall    = pin_d_q[0] & ~pin_s_q[0];
  assign cs_rise    = ~pin_d_q[0] & pin_s_q[0];
  assign sck_s      = pin_s_q[1];
  // Clock pulses only count while selected
  assign x_rise     = ~cs_n_s & ~pin_d_q[1] & pin_s_q[1];
  assign x_fall     = ~cs_n_s & pin_d_q[1] & ~pin_s_q[1];
  assign notch_rise = ~pin_d_q[2] & pin_s_q[2];

  // ----------------------------------------------------------------
  // Conversion clock source
  // ----------------------------------------------------------------
  logic [NW-1:0] gap_q;
  logic          conv_tick_w;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      gap_q        <= '0;
      ext_conv_clk <= 1'b0;
      osc_en       <= 1'b1;
    end else if (notch_rise) begin
      gap_q        <= '0;
      ext_conv_clk <= 1'b1;
      osc_en       <= 1'b0;
    end else if (gap_q == NW'(NOTCH_WIN_CYC - 1)) begin
      // Edges too sparse for the minimum rate: fall back
      ext_conv_clk <= 1'b0;
      osc_en       <= 1'b1;
    end else begin
      gap_q <= gap_q + NW'(1);
    end
  end

  // The switch is glitch free for the data path: only tick spacing changes
  assign conv_tick_w = ext_conv_clk ? notch_rise : (osc_en & int_osc_tick);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      conv_tick <= 1'b0;
    end else begin
      conv_tick <= conv_tick_w;
    end
  end

  // ----------------------------------------------------------------
  // Result buffer
  // ----------------------------------------------------------------
  aro_state_t st_q;
  logic       buf_valid;
  logic       buf_take;
  logic [31:0] buf_data;

  assign buf_take = (st_q == ARO_ST_CONV);

  aro_pair_buf #(
    .W (32)
  ) u_buf (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (res_valid),
    .in_ready  (res_ready),
    .in_data   ({res_over, res_under, res_code}),
    .out_valid (buf_valid),
    .out_ready (buf_take),
    .out_data  (buf_data)
  );

  function automatic aro_word_t fmt_word(input logic [31:0] b);
    logic [29:0] low;
    low = {~b[29], b[28:0]};
    if (b[31]) begin
      low = `ARO_OVER_CODE;
    end else if (b[30]) begin
      low = `ARO_UNDER_CODE;
    end
    // Pending clear, filler low
    fmt_word = {1'b0, 1'b0, low};
  endfunction

  // ----------------------------------------------------------------
  // Serial clock mode
  // ----------------------------------------------------------------
  logic [1:0] por_cnt_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      por_cnt_q    <= 2'h0;
      ext_sck_mode <= 1'b0;
    end else begin
      if (por_cnt_q != 2'h3) begin
        por_cnt_q <= por_cnt_q + 2'h1;
      end
      // Sample once the synchroniser holds a true pin level
      if (por_cnt_q == 2'h2 || cs_fall) begin
        ext_sck_mode <= ~sck_s;
      end
    end
  end

  // ----------------------------------------------------------------
  // Internal serial clock generator
  // ----------------------------------------------------------------
  logic [1:0] div_q;
  logic       gen_run;
  logic       gen_edge;
  logic       i_rise;
  logic       i_fall;
  logic       rise_ev;
  logic       fall_ev;

  // Runs in internal mode while a word waits or shifts with select low: a host that keeps select low goes on reading words
  assign gen_run  = ~ext_sck_mode & ~cs_n_s &
                    ((st_q == ARO_ST_SLEEP) | (st_q == ARO_ST_OUT));
  assign gen_edge = gen_run & conv_tick_w & (div_q == `ARO_SCK_HALF_TICKS);
  assign i_rise   = gen_edge & ~sck_out;
  assign i_fall   = gen_edge & sck_out;
  assign rise_ev  = ext_sck_mode ? x_rise : i_rise;
  assign fall_ev  = ext_sck_mode ? x_fall : i_fall;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      div_q   <= 2'h0;
      sck_out <= 1'b0;
    end else if (!gen_run) begin
      div_q   <= 2'h0;
      sck_out <= 1'b0;
    end else if (conv_tick_w) begin
      div_q <= div_q + 2'h1;
      if (gen_edge) begin
        sck_out <= ~sck_out;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sck_oe <= 1'b0;
    end else begin
      // Off on the select edge and before the power-up sample: the host may still
      // drive the line in that cycle, and driving it too would collide
      sck_oe <= ~ext_sck_mode & ~cs_n_s & ~cs_fall &
                (por_cnt_q == 2'h3);
    end
  end

  // ----------------------------------------------------------------
  // Conversion cycle
  // ----------------------------------------------------------------
  // Falls within one word; cleared with every new word
  logic [4:0] fall_cnt_q;
  logic       last_fall;

  assign last_fall = fall_ev & (fall_cnt_q == `ARO_LAST_FALL);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q <= ARO_ST_START;
    end else begin
      case (st_q)
        ARO_ST_START: begin
          st_q <= ARO_ST_CONV;
        end
        ARO_ST_CONV: begin
          if (buf_valid) begin
            st_q <= ARO_ST_SLEEP;
          end
        end
        ARO_ST_SLEEP: begin
          // First rise with chip select low opens the output
          if (rise_ev) begin
            st_q <= ARO_ST_OUT;
          end
        end
        ARO_ST_OUT: begin
          if (cs_rise) begin
            st_q <= ARO_ST_START;
          end else if (last_fall) begin
            st_q <= ARO_ST_START;
          end
        end
        default: begin
          st_q <= ARO_ST_START;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      conv_start <= 1'b0;
      conv_busy  <= 1'b1;
      out_active <= 1'b0;
      xfer_abort <= 1'b0;
    end else begin
      conv_start <= (st_q == ARO_ST_START);
      // A word already waiting lets the flag drop right after start
      conv_busy  <= (st_q == ARO_ST_START) |
                    ((st_q == ARO_ST_CONV) & ~buf_valid);
      out_active <= ((st_q == ARO_ST_SLEEP) & rise_ev) |
                    ((st_q == ARO_ST_OUT) & ~cs_rise & ~last_fall);
      xfer_abort <= (st_q == ARO_ST_OUT) & cs_rise;
    end
  end

  // ----------------------------------------------------------------
  // Output shift register
  // ----------------------------------------------------------------
  aro_word_t shift_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      shift_q    <= `ARO_SHIFT_RST;
      fall_cnt_q <= 5'h00;
    end else if (st_q == ARO_ST_CONV && buf_valid) begin
      // Held static through sleep
      shift_q    <= fmt_word(buf_data);
      fall_cnt_q <= 5'h00;
    end else if (st_q == ARO_ST_OUT && fall_ev) begin
      shift_q    <= {shift_q[30:0], 1'b1};
      fall_cnt_q <= fall_cnt_q + 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // Data output pin
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sdo_out <= 1'b1;
      sdo_oe  <= 1'b0;
    end else begin
      sdo_oe <= ~cs_n_s;
      case (st_q)
        ARO_ST_START: begin
          sdo_out <= 1'b1;
        end
        ARO_ST_CONV: begin
          // Flag drops as soon as the result lands
          sdo_out <= ~buf_valid;
        end
        ARO_ST_SLEEP: begin
          sdo_out <= shift_q[`ARO_PEND_BIT];
        end
        ARO_ST_OUT: begin
          if (cs_rise || last_fall) begin
            sdo_out <= 1'b1;
          end else if (fall_ev) begin
            sdo_out <= shift_q[`ARO_FILL_BIT];
          end
        end
        default: begin
          sdo_out <= 1'b1;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== rtl/aro_defs.svh ====
`ifndef ARO_DEFS_SVH
`define ARO_DEFS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ARO_CLK_HZ          250000000
`define ARO_NOTCH_MIN_HZ    2560
// Longest gap between notch clock edges still seen as a clock, rounded down
`define ARO_NOTCH_WIN_CYC   (`ARO_CLK_HZ / `ARO_NOTCH_MIN_HZ)
// Serial clock is conversion clock / 8: toggle every 4 conversion ticks
`define ARO_SCK_HALF_TICKS  2'h3

// ----------------------------------------------------------------
// Output word layout
// ----------------------------------------------------------------
`define ARO_WORD_W          32
`define ARO_PEND_BIT        31
`define ARO_FILL_BIT        30
`define ARO_POL_BIT         29
`define ARO_MSB_BIT         28
`define ARO_LSB_BIT         5
`define ARO_LAST_FALL       5'h1F
`define ARO_OVER_CODE       30'h3000_0000
`define ARO_UNDER_CODE      30'h0FFF_FFFF

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ARO_PIN_RST         3'h3
`define ARO_SHIFT_RST       32'h8000_0000

`endif

// ==== rtl/aro_pkg.sv ====
package aro_pkg;

  // Signed conversion code: sign, MSB..LSB, then 5 sub-LSBs
  typedef logic [29:0] aro_code_t;
  typedef logic [31:0] aro_word_t;

  typedef enum logic [3:0] {
    ARO_ST_START = 4'b0001,
    ARO_ST_CONV  = 4'b0010,
    ARO_ST_SLEEP = 4'b0100,
    ARO_ST_OUT   = 4'b1000
  } aro_state_t;

endpackage

// ==== rtl/aro_pair_buf.sv ====
`timescale 1ns/1ps
`default_nettype none
module aro_pair_buf #(
  parameter int unsigned W = 32
) (
  input  wire logic         clk,        // System clock
  input  wire logic         nrst,       // Synchronous reset, active low
  input  wire logic         in_valid,   // Word offered
  output logic              in_ready,   // Space free, registered
  input  wire logic [W-1:0] in_data,    // Word in
  output logic              out_valid,  // Word held
  input  wire logic         out_ready,  // Drain side takes word
  output logic [W-1:0]      out_data    // Oldest word
);

  logic [W-1:0] mem_q [2];
  logic         wp_q;
  logic         rp_q;
  logic [1:0]   cnt_q;
  logic [1:0]   cnt_d;
  logic         push;
  logic         pop;

  assign out_valid = (cnt_q != 2'h0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_q[rp_q];

  always_comb begin
    cnt_d = cnt_q;
    if (push & ~pop) begin
      cnt_d = cnt_q + 2'h1;
    end else if (pop & ~push) begin
      cnt_d = cnt_q - 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Pointers and occupancy
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_q    <= 2'h0;
      wp_q     <= 1'b0;
      rp_q     <= 1'b0;
      in_ready <= 1'b1;
    end else begin
      cnt_q    <= cnt_d;
      in_ready <= (cnt_d != 2'h2);
      if (push) begin
        wp_q <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
    end
  end

  // Storage needs no reset: nothing reads an empty slot
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

endmodule
`default_nettype wire

// ==== sim/aro_serial_out_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module aro_serial_out_props #(
  parameter int NOTCH_WIN_CYC = 64
) (
  input wire logic clk,             // System clock
  input wire logic nrst,            // Reset, active low
  input wire logic cs_n_pin,        // Chip select
  input wire logic notch_clock_pin, // Notch clock
  input wire logic sck_oe,          // Serial clock enable
  input wire logic sdo_out,         // Serial data
  input wire logic sdo_oe,          // Serial data enable
  input wire logic osc_en,          // Oscillator on
  input wire logic ext_conv_clk,    // Notch clock in use
  input wire logic ext_sck_mode,    // External clock mode
  input wire logic conv_start,      // Conversion start
  input wire logic conv_busy,       // Converting
  input wire logic out_active,      // Output state
  input wire logic xfer_abort,      // Abort pulse
  input wire logic conv_tick,       // Conversion tick
  input wire logic sck_out          // Serial clock driven
);
  logic        notch_q;
  int unsigned gap_q;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // ------------------------------------------------------------
  // Cycles since the last notch rise, saturating
  // ------------------------------------------------------------
  always_ff @(posedge clk) notch_q <= notch_clock_pin;
  always_ff @(posedge clk) begin
    if (!nrst || (notch_clock_pin && !notch_q)) begin
      gap_q <= 0;
    end else if (gap_q < NOTCH_WIN_CYC + 8) begin
      gap_q <= gap_q + 1;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_float_deselect: assert property ((cs_n_pin)[*5] |-> !sdo_oe && !sck_oe)
    else $error("data or clock driven while deselected");
  a_drive_select: assert property ((!cs_n_pin)[*5] |-> sdo_oe)
    else $error("data not driven while selected");
  a_pend_drop: assert property ($fell(conv_busy) && sdo_oe |-> !sdo_out)
    else $error("pending flag stays high after conversion end");
  a_start_busy: assert property (conv_start |-> conv_busy)
    else $error("conversion start without busy");
  a_abort_restart: assert property (xfer_abort |-> ##[0:4] conv_start)
    else $error("abort without new conversion");
  a_abort_seen: assert property (out_active && $rose(cs_n_pin) |-> ##[1:5] xfer_abort)
    else $error("chip select rise in output not aborted");
  a_new_conv_high: assert property (conv_start && sdo_oe && !cs_n_pin |-> sdo_out)
    else $error("data low at new conversion");
  a_osc_exclusive: assert property (osc_en != ext_conv_clk)
    else $error("oscillator and notch clock disagree");
  a_notch_detect: assert property ($rose(notch_clock_pin) |-> ##[1:5] ext_conv_clk)
    else $error("notch clock not detected");
  a_osc_return: assert property (gap_q == NOTCH_WIN_CYC + 8 |-> osc_en && !ext_conv_clk)
    else $error("oscillator not back after notch stops");
  a_mode_ext: assert property (ext_sck_mode |-> !sck_oe)
    else $error("serial clock driven in external mode");
  a_sck_quiet: assert property (!sck_oe |-> !sck_out)
    else $error("serial clock toggles while not driven");
  a_tick_follow: assert property (ext_conv_clk && $rose(notch_clock_pin) |-> ##[2:4] conv_tick)
    else $error("notch clock edge gave no conversion tick");

  c_abort: cover property (xfer_abort);
  c_int_word: cover property (sck_oe && out_active);
  c_full_word: cover property ($fell(out_active) && !cs_n_pin);
  c_notch: cover property ($rose(ext_conv_clk));
endmodule

bind aro_serial_out aro_serial_out_props #(.NOTCH_WIN_CYC(NOTCH_WIN_CYC)) i_props (
  .clk(clk), .nrst(nrst), .cs_n_pin(cs_n_pin), .notch_clock_pin(notch_clock_pin),
  .sck_oe(sck_oe), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .osc_en(osc_en),
  .ext_conv_clk(ext_conv_clk), .ext_sck_mode(ext_sck_mode), .conv_start(conv_start),
  .conv_busy(conv_busy), .out_active(out_active), .xfer_abort(xfer_abort),
  .conv_tick(conv_tick), .sck_out(sck_out)
);
`default_nettype wire

// ==== sim/aro_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module aro_host_model (
  input  wire logic clk,     // System clock
  input  wire logic sdo_out, // Device data
  input  wire logic sdo_oe,  // Device drives data
  input  wire logic sck_line, // Serial clock as seen on the pin
  output var  logic cs_n,    // Chip select, active low
  output var  logic sck      // Serial clock, external mode
);
  logic last_q = 1'b0;
  logic sdo_w;

  // Released line has no pull: show the inverse of the last driven bit
  assign sdo_w = sdo_oe ? sdo_out : ~last_q;
  always @(posedge clk) if (sdo_oe) last_q <= sdo_out;
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
  end

  task automatic half();
    repeat (8) @(posedge clk);
  endtask

  task automatic xfer(input int n, input bit idle, output logic [31:0] w);
    w = 32'h0000_0000;
    if (idle) repeat (4) begin // pulses while deselected
      sck <= 1'b1;
      half();
      sck <= 1'b0;
      half();
    end
    cs_n <= 1'b0; // clock low at this fall selects external mode
    half();
    half();
    for (int i = 0; i < n; i++) begin
      sck <= 1'b1;
      @(posedge clk);
      w = {w[30:0], sdo_w}; // sampled on the rise only
      repeat (7) @(posedge clk);
      sck <= 1'b0;
      half();
    end
    cs_n <= 1'b1; // early rise aborts the word
    half();
  endtask

  // Device makes the clock: sample on each rise it drives, deselect right after bit 0
  task automatic xfer_int(output logic [31:0] w);
    logic prev;
    w    = 32'h0000_0000;
    prev = 1'b1;
    sck  <= 1'b1; // line high at the select edge picks internal mode
    half();
    cs_n <= 1'b0;
    for (int i = 0; i < 32; i++) begin
      @(posedge clk);
      while (!(sck_line && !prev)) begin
        prev = sck_line;
        @(posedge clk);
      end
      prev = sck_line;
      w = {w[30:0], sdo_w};
    end
    cs_n <= 1'b1; // before the device opens the next word
    half();
    sck  <= 1'b0;
    half();
  endtask
endmodule
`default_nettype wire

// ==== sim/aro_serial_out_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module aro_serial_out_tb_top;
  import aro_pkg::*;
  localparam int NR = 12;
  logic        clk = 1'b0, nrst = 1'b0, notch_clock_pin = 1'b0, int_osc_tick = 1'b0;
  logic        res_valid = 1'b0, res_over = 1'b0, res_under = 1'b0, notch_run = 1'b0;
  aro_code_t   res_code = '0;
  logic        cs_n_pin, sck_host, sck_in, sck_out, sck_oe, sdo_out, sdo_oe, osc_en, ext_conv_clk;
  logic        ext_sck_mode, conv_start, conv_busy, out_active, xfer_abort, conv_tick, res_ready;
  int          error_cnt = 0, tests_run = 0, n;
  integer      seed = 32'he65c5db2;
  logic [31:0] w, e;
  logic [31:0] exp_q[$];

  assign sck_in = sck_oe ? sck_out : sck_host;

  aro_serial_out #(.NOTCH_WIN_CYC(64)) i_aro_serial_out (
    .clk(clk), .nrst(nrst), .cs_n_pin(cs_n_pin), .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe),
    .sdo_out(sdo_out), .sdo_oe(sdo_oe), .notch_clock_pin(notch_clock_pin), .int_osc_tick(int_osc_tick),
    .osc_en(osc_en), .ext_conv_clk(ext_conv_clk), .ext_sck_mode(ext_sck_mode), .conv_start(conv_start),
    .conv_busy(conv_busy), .out_active(out_active), .xfer_abort(xfer_abort), .conv_tick(conv_tick),
    .res_valid(res_valid), .res_ready(res_ready), .res_code(res_code), .res_over(res_over),
    .res_under(res_under)
  );
  aro_host_model i_aro_host_model (
    .clk(clk), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .sck_line(sck_in), .cs_n(cs_n_pin), .sck(sck_host)
  );

  initial forever #2 clk = ~clk;
  always @(posedge clk) int_osc_tick <= (($random(seed) & 3) == 0);
  always begin
    repeat (4) @(posedge clk);
    if (notch_run) notch_clock_pin <= ~notch_clock_pin;
  end

  // ------------------------------------------------------------
  // Checking and closing
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("mismatches=%0d compares=%0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Source offers back to back; edge cases first, then random codes
  task automatic feed();
    logic      ov, un;
    aro_code_t c;
    int        v;
    logic [31:0] x;
    for (int i = 0; i < NR + 3; i++) begin
      c = (i == 3) ? 30'h0000_0000 : (i == 4) ? 30'h3FFF_FFFF : (i == 5) ? 30'h3000_0000 :
          (i == 6) ? 30'h0FFF_FFFF : aro_code_t'($random(seed));
      // In-range codes only: the sign repeats the MSB
      if (i > 6) c[29] = c[28];
      v = $signed(c);
      // Integer model: zero and positive keep bit 29 high, negatives are offset by 2^29
      x = (v >= 0) ? {3'b001, 29'(v)} : {3'b000, 29'(v + 32'sh2000_0000)};
      ov = (i == 0) || (i == 2);
      un = (i == 1) || (i == 2);
      res_code  <= c;
      res_over  <= ov;
      res_under <= un;
      res_valid <= 1'b1;
      @(posedge clk);
      while (res_ready !== 1'b1) @(posedge clk);
      exp_q.push_back(ov ? 32'h3000_0000 : un ? 32'h0FFF_FFFF : x);
    end
    res_valid <= 1'b0;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    chk({sdo_oe, conv_busy, osc_en, res_ready}, 32'h0000_0007);
    nrst <= 1'b1;
    fork
      feed();
    join_none
    repeat (300) @(posedge clk);
    chk({res_ready, conv_busy, ext_sck_mode}, 32'h0000_0001);
    for (int r = 0; r < NR; r++) begin
      n = (r % 4 == 3) ? 10 : 32;
      notch_run = (r == 5) || (r == 9);
      if (r == 8 || r == 9) begin
        i_aro_host_model.xfer_int(w);
        chk(ext_sck_mode, 32'h0000_0000);
      end else begin
        i_aro_host_model.xfer(n, r == 1, w);
      end
      e = exp_q.pop_front();
      chk(w, e >> (32 - n));
      if (notch_run) begin
        chk({ext_conv_clk, osc_en}, 32'h0000_0002);
        notch_run = 1'b0;
        repeat (120) @(posedge clk);
        chk({ext_conv_clk, osc_en}, 32'h0000_0001);
      end
      repeat (60) @(posedge clk);
    end
    tally_and_finish();
  end

  initial begin
    repeat (40000) @(posedge clk);
    chk(32'h0000_0001, 32'h0000_0000);
    tally_and_finish();
  end
endmodule
`default_nettype wire
